// ---- inc/orc_pkg.sv ----
// Package with register map, field layout, reset values and types of the over-range and mode configuration block.
package orc_pkg;

  // Register byte addresses on the serial register port.
  localparam logic [15:0] ORC_ADDR_OPERATING_MODE_TWO = 16'h0013;
  localparam logic [15:0] ORC_ADDR_IMBALANCE_TRIM     = 16'h0014;
  localparam logic [15:0] ORC_ADDR_OVR_ENABLE         = 16'h003A;
  localparam logic [15:0] ORC_ADDR_OVERRANGE_HOLD_CTRL           = 16'h003B;
  localparam logic [15:0] ORC_ADDR_OVR_THRESHOLD      = 16'h003C;

  // Reset values.
  localparam logic [7:0] ORC_RST_OPERATING_MODE_TWO = 8'h20;
  localparam logic [7:0] ORC_RST_IMBALANCE_TRIM     = 8'h00;
  localparam logic [7:0] ORC_RST_OVR_ENABLE         = 8'h00;
  localparam logic [7:0] ORC_RST_OVERRANGE_HOLD_CTRL           = 8'h00;
  localparam logic [7:0] ORC_RST_OVR_THRESHOLD      = 8'h00;
  localparam logic [7:0] ORC_RDATA_UNMAPPED         = 8'h00;

  // Field positions.
  localparam int ORC_CLOCK_DIVIDE_RATIO_LSB = 0;
  localparam int ORC_AMP_LSB    = 4;
  localparam int ORC_PHASE_LSB  = 0;
  localparam int ORC_OVERRANGE_ENABLE_BIT = 0;
  localparam int ORC_HOLD_LSB   = 0;
  localparam int ORC_TH_SHIFT   = 7;

  // Clock divide codes.
  localparam logic [1:0] ORC_DIV_BY_1 = 2'h0;
  localparam logic [1:0] ORC_DIV_BY_2 = 2'h1;
  localparam logic [1:0] ORC_DIV_BY_4 = 2'h2;

  // Hold extension in sampling-clock periods per hold code.
  localparam logic [3:0] ORC_HOLD_EXT_0 = 4'h0;
  localparam logic [3:0] ORC_HOLD_EXT_1 = 4'h3;
  localparam logic [3:0] ORC_HOLD_EXT_2 = 4'h7;
  localparam logic [3:0] ORC_HOLD_EXT_3 = 4'hF;

  // Full-scale limits used when the threshold setting is zero; only +32767 and -32768 lie beyond them.
  localparam logic signed [17:0] ORC_FS_POS_LIM = 18'sh07FFE;
  localparam logic signed [17:0] ORC_FS_NEG_LIM = -18'sh07FFF;

  // Register port request from the serial register host.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } orc_reg_req_t;

  // Register port answer.
  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } orc_reg_rsp_t;

  // State of the block apart from the reset synchronizer.
  typedef struct packed {
    logic [7:0]  operating_mode_two;
    logic [7:0]  input_imbalance_trim;
    logic [7:0]  overrange_enable_ctrl;
    logic [7:0]  overrange_hold_ctrl;
    logic [7:0]  overrange_threshold_ctrl;
    logic [1:0]  div_cnt;
    logic        tick_d1;
    logic        over_hit;
    logic [3:0]  hold_cnt;
    logic        overrange_flag;
    logic        serial_data_out_pin;
    logic        sample_tick;
    orc_reg_rsp_t rsp;
  } orc_state_t;

endpackage

// ---- rtl/orc_overrange_config.sv ----
// Configuration registers, sampling-clock divider and over-range detector with hold extension.
//
// What this block does
// - Divide field codes 00, 01, 10 select divide by one, two, four; 11 reserved.
// - Operating mode two sits at 0x0013 and resets to 0x20, divide by one.
// - Imbalance trim bits 6:4 hold amplitude trim; zero default, code 4 reserved.
// - Imbalance trim bits 3:0 hold phase trim; zero default, code 8 reserved.
// - Enable bit 0 keeps over-range inactive; 1 drives indication on data-out pin.
// - A sample beyond full scale registers an over-range event and asserts indicators.
// - After the event the indicator stays 0, 3, 7 or 15 extra cycles by code.
// - Hold extension counts internal sampling clock periods, after the divider.
// - Assertion and release follow the sampled condition with equal fixed latency.
// - Threshold register sits at 0x003C and resets to zero.
module orc_overrange_config
  import orc_pkg::*;
(
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  // Serial register port.
  input  wire orc_reg_req_t reg_req_i,
  output      orc_reg_rsp_t reg_rsp_o,
  // Converted samples, same clock.
  input  wire logic [15:0]  sample_i,
  // Configuration outputs.
  output      logic [2:0]   amplitude_trim_code_o,
  output      logic [3:0]   phase_trim_code_o,
  output      logic         sample_tick_o,
  // Over-range indication.
  output      logic         overrange_flag_o,
  output      logic         serial_data_out_pin_o
);

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  orc_state_t        st_q;
  orc_state_t        st_d;
  logic [1:0]        div_mask;
  logic              tick;
  logic signed [17:0] pos_lim;
  logic signed [17:0] neg_lim;
  logic signed [17:0] smp_ext;
  logic              over_now;
  logic [3:0]        hold_ext;
  logic              ovr_on;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Divider mask and sampling tick; the reserved code falls back to divide by one.
  always_comb begin
    case (st_q.operating_mode_two[ORC_CLOCK_DIVIDE_RATIO_LSB +: 2])
      ORC_DIV_BY_2: div_mask = 2'h1;
      ORC_DIV_BY_4: div_mask = 2'h3;
      default:      div_mask = 2'h0;
    endcase
    tick = ((st_q.div_cnt & div_mask) == 2'h0);
  end

  // Symmetric limits; a zero setting means the full-scale codes themselves count as over-range.
  always_comb begin
    smp_ext = 18'(signed'(sample_i));
    if (st_q.overrange_threshold_ctrl == 8'h00) begin
      pos_lim = ORC_FS_POS_LIM;
      neg_lim = ORC_FS_NEG_LIM;
    end else begin
      pos_lim = signed'({3'h0, st_q.overrange_threshold_ctrl, 7'h00});
      neg_lim = -pos_lim;
    end
    over_now = (smp_ext > pos_lim) || (smp_ext < neg_lim);
  end

  // Extra hold periods per hold code.
  always_comb begin
    case (st_q.overrange_hold_ctrl[ORC_HOLD_LSB +: 2])
      2'h1:    hold_ext = ORC_HOLD_EXT_1;
      2'h2:    hold_ext = ORC_HOLD_EXT_2;
      2'h3:    hold_ext = ORC_HOLD_EXT_3;
      default: hold_ext = ORC_HOLD_EXT_0;
    endcase
  end

  assign ovr_on = st_q.overrange_enable_ctrl[ORC_OVERRANGE_ENABLE_BIT];

  // Next-state logic: register port, divider and two-stage detector pipeline.
  always_comb begin
    st_d             = st_q;
    st_d.div_cnt     = 2'(st_q.div_cnt + 2'h1);
    st_d.sample_tick = tick;
    st_d.tick_d1     = tick;
    st_d.rsp.rvalid  = 1'b0;
    // Register writes; reserved bits are stored as written.
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == ORC_ADDR_OPERATING_MODE_TWO) begin
        st_d.operating_mode_two = reg_req_i.wdata;
      end else if (reg_req_i.addr == ORC_ADDR_IMBALANCE_TRIM) begin
        st_d.input_imbalance_trim = reg_req_i.wdata;
      end else if (reg_req_i.addr == ORC_ADDR_OVR_ENABLE) begin
        st_d.overrange_enable_ctrl = reg_req_i.wdata;
      end else if (reg_req_i.addr == ORC_ADDR_OVERRANGE_HOLD_CTRL) begin
        st_d.overrange_hold_ctrl = reg_req_i.wdata;
      end else if (reg_req_i.addr == ORC_ADDR_OVR_THRESHOLD) begin
        st_d.overrange_threshold_ctrl = reg_req_i.wdata;
      end
    end
    // Register reads answer one cycle later; unmapped addresses read zero.
    if (reg_req_i.rd) begin
      st_d.rsp.rvalid = 1'b1;
      if (reg_req_i.addr == ORC_ADDR_OPERATING_MODE_TWO) begin
        st_d.rsp.rdata = st_q.operating_mode_two;
      end else if (reg_req_i.addr == ORC_ADDR_IMBALANCE_TRIM) begin
        st_d.rsp.rdata = st_q.input_imbalance_trim;
      end else if (reg_req_i.addr == ORC_ADDR_OVR_ENABLE) begin
        st_d.rsp.rdata = st_q.overrange_enable_ctrl;
      end else if (reg_req_i.addr == ORC_ADDR_OVERRANGE_HOLD_CTRL) begin
        st_d.rsp.rdata = st_q.overrange_hold_ctrl;
      end else if (reg_req_i.addr == ORC_ADDR_OVR_THRESHOLD) begin
        st_d.rsp.rdata = st_q.overrange_threshold_ctrl;
      end else begin
        st_d.rsp.rdata = ORC_RDATA_UNMAPPED;
      end
    end
    // Stage one samples the comparison once per sampling period.
    if (tick) begin
      st_d.over_hit = over_now;
    end
    // Stage two clears indicator and hold count every cycle while disabled; when enabled it updates them once per sampling period.
    if (!ovr_on) begin
      st_d.hold_cnt            = 4'h0;
      st_d.overrange_flag      = 1'b0;
      st_d.serial_data_out_pin = 1'b0;
    end else if (st_q.tick_d1) begin
      if (st_q.over_hit) begin
        st_d.hold_cnt = hold_ext;
      end else if (st_q.hold_cnt != 4'h0) begin
        st_d.hold_cnt = 4'(st_q.hold_cnt - 4'h1);
      end
      st_d.overrange_flag      = st_q.over_hit || (st_q.hold_cnt != 4'h0);
      st_d.serial_data_out_pin = st_q.over_hit || (st_q.hold_cnt != 4'h0);
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q                          <= '0;
      st_q.operating_mode_two       <= ORC_RST_OPERATING_MODE_TWO;
      st_q.input_imbalance_trim     <= ORC_RST_IMBALANCE_TRIM;
      st_q.overrange_enable_ctrl    <= ORC_RST_OVR_ENABLE;
      st_q.overrange_hold_ctrl      <= ORC_RST_OVERRANGE_HOLD_CTRL;
      st_q.overrange_threshold_ctrl <= ORC_RST_OVR_THRESHOLD;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from state flip-flops.
  assign reg_rsp_o             = st_q.rsp;
  assign amplitude_trim_code_o = st_q.input_imbalance_trim[ORC_AMP_LSB +: 3];
  assign phase_trim_code_o     = st_q.input_imbalance_trim[ORC_PHASE_LSB +: 4];
  assign sample_tick_o         = st_q.sample_tick;
  assign overrange_flag_o      = st_q.overrange_flag;
  assign serial_data_out_pin_o = st_q.serial_data_out_pin;

  // Checks on the behaviour above.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_hit_sampled;
    tick && over_now && ovr_on;
  endsequence

  sequence s_clear_sampled;
    tick && !over_now && ovr_on && st_q.hold_cnt == 4'h0 && st_q.overrange_hold_ctrl[1:0] == 2'h0;
  endsequence

  a_div_ratio_tick: assert property (
    (st_q.operating_mode_two[1:0] == 2'h1 && tick && $stable(st_q.operating_mode_two)
      && !(reg_req_i.wr && reg_req_i.addr == ORC_ADDR_OPERATING_MODE_TWO)) |=> !tick
  ) else $error("Divide by two produced back to back ticks.");

  a_om2_read_back: assert property (
    (reg_req_i.rd && reg_req_i.addr == ORC_ADDR_OPERATING_MODE_TWO)
      |=> (reg_rsp_o.rvalid && reg_rsp_o.rdata == $past(st_q.operating_mode_two))
  ) else $error("Operating mode two read returned wrong data.");

  a_amp_trim_write: assert property (
    (reg_req_i.wr && reg_req_i.addr == ORC_ADDR_IMBALANCE_TRIM)
      |=> ##1 amplitude_trim_code_o == $past(reg_req_i.wdata[6:4], 2)
  ) else $error("Amplitude trim did not follow the write.");

  a_phase_trim_write: assert property (
    (reg_req_i.wr && reg_req_i.addr == ORC_ADDR_IMBALANCE_TRIM)
      |=> ##1 phase_trim_code_o == $past(reg_req_i.wdata[3:0], 2)
  ) else $error("Phase trim did not follow the write.");

  a_pin_when_off: assert property (
    !ovr_on |=> (!serial_data_out_pin_o && !overrange_flag_o)
  ) else $error("Indication driven while over-range is disabled.");

  a_hit_asserts_flag: assert property (
    s_hit_sampled |-> ##2 (overrange_flag_o || !ovr_on)
  ) else $error("Over-range sample did not raise the flag after two cycles.");

  a_release_latency: assert property (
    s_clear_sampled ##0 (st_q.tick_d1 == 1'b0 || !st_q.over_hit) |-> ##2 !overrange_flag_o
  ) else $error("Flag release latency differs from assertion latency.");

  a_hold_three_ext: assert property (
    (st_q.tick_d1 && st_q.over_hit && ovr_on && st_q.overrange_hold_ctrl[1:0] == 2'h1
      && div_mask == 2'h0 && !reg_req_i.wr) |=> overrange_flag_o [*4]
  ) else $error("Hold code one did not extend by three periods.");

  a_hold_divided: assert property (
    (st_q.tick_d1 && st_q.over_hit && ovr_on && st_q.overrange_hold_ctrl[1:0] == 2'h1
      && div_mask == 2'h1 && !reg_req_i.wr) |=> overrange_flag_o [*8]
  ) else $error("Hold extension not counted in divided clock periods.");

  a_th_read_back: assert property (
    (reg_req_i.rd && reg_req_i.addr == ORC_ADDR_OVR_THRESHOLD) |=> reg_rsp_o.rdata == $past(st_q.overrange_threshold_ctrl)
  ) else $error("Threshold read returned wrong data.");

  a_thresh_compare: assert property (
    (tick && st_q.overrange_threshold_ctrl != 8'h00
      && $signed(sample_i) > $signed({1'b0, st_q.overrange_threshold_ctrl, 7'h00})) |=> st_q.over_hit
  ) else $error("Sample above threshold was not flagged.");

  a_hold_restart: assert property (
    (st_q.tick_d1 && st_q.over_hit && ovr_on && st_q.hold_cnt != 4'h0) |=> st_q.hold_cnt == $past(hold_ext)
  ) else $error("New event did not restart the hold count.");

endmodule

// ---- dv/orc_host_model.sv ----
// Serial register host model that issues one-cycle register requests.
module orc_host_model
  import orc_pkg::*;
(
  // Clock.
  input  wire logic         clk_i,
  // Register port.
  output      orc_reg_req_t reg_req_o,
  input  wire orc_reg_rsp_t reg_rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle request at time zero.
  initial reg_req_o = '0;

  // Forces reserved bits to the patterns the device expects.
  function automatic logic [7:0] fix(input logic [15:0] a, input logic [7:0] d);
    case (a)
      ORC_ADDR_OPERATING_MODE_TWO: fix = {6'h08, d[1:0]};
      ORC_ADDR_IMBALANCE_TRIM:     fix = {1'h0, d[6:0]};
      ORC_ADDR_OVR_ENABLE:         fix = {7'h00, d[0]};
      ORC_ADDR_OVERRANGE_HOLD_CTRL:           fix = {6'h00, d[1:0]};
      default:                     fix = d;
    endcase
  endfunction

  // One write pulse; address and data are scrambled once released.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: fix(a, d)};
    @(negedge clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read pulse; the answer stands from the taking edge for exactly one cycle.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    // The answer stands only in this cycle, so it is taken before the release.
    ok = reg_rsp_i.rvalid;
    d  = reg_rsp_i.rdata;
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule

// ---- dv/orc_overrange_config_tb.sv ----
// Self-checking testbench for the over-range and mode configuration block.
module orc_overrange_config_tb import orc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic         ref_clk, reset_n, tick, flag, pin;
  logic [15:0]  sample;
  logic [2:0]   amp;
  logic [3:0]   ph;
  orc_reg_req_t req;
  orc_reg_rsp_t rsp;
  int           n_fail, checks_done, hi, pin_hi, first, falls;
  logic [15:0]  addrs[6] = '{16'h0013, 16'h0014, 16'h003A, 16'h003B, 16'h003C, 16'h0015};
  logic [7:0]   rsts[6]  = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int           ext[4]   = '{0, 3, 7, 15};
  int           ticks[4] = '{16, 8, 4, 16};
  logic [15:0]  th_s[4]  = '{16'h0080, 16'h0081, 16'hFF80, 16'hFF7F};

  // Design and host model.
  orc_overrange_config DUT (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .reg_req_i(req), .reg_rsp_o(rsp),
    .sample_i(sample), .amplitude_trim_code_o(amp), .phase_trim_code_o(ph), .sample_tick_o(tick),
    .overrange_flag_o(flag), .serial_data_out_pin_o(pin));
  orc_host_model HOST (.clk_i(ref_clk), .reg_req_o(req), .reg_rsp_i(rsp));

  // Clock at 25 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compares a value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a register and compares the answer.
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    HOST.rd(a, d, ok);
    chk(ok, 1'b1);
    chk(d, exp);
  endtask

  // Plays samples one per cycle and measures the indicator during playback and for 40 cycles after.
  task automatic run(input logic [15:0] s[$]);
    logic prev;
    hi = 0; pin_hi = 0; first = -1; falls = 0; prev = 1'b0;
    for (int k = 0; k < s.size() + 40; k++) begin
      @(negedge ref_clk);
      if (flag === 1'b1 && first < 0) first = k;
      if (flag === 1'b1) hi++;
      if (pin === 1'b1) pin_hi++;
      if (prev === 1'b1 && flag === 1'b0) falls++;
      prev = flag;
      sample = (k < s.size()) ? s[k] : 16'h0000;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    n_fail++;
    close_out();
  end

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    sample  = 16'h0000;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    foreach (addrs[i]) rchk(addrs[i], rsts[i]);
    chk(amp, 3'h0);
    chk(ph, 4'h0);
    HOST.wr(16'h0014, 8'h7A);
    repeat (2) @(negedge ref_clk);
    chk(amp, 3'h7);
    chk(ph, 4'hA);
    rchk(16'h0014, 8'h7A);
    for (int c = 0; c < 4; c++) begin
      HOST.wr(16'h0013, c[7:0]);
      rchk(16'h0013, 8'h20 | c[7:0]);
      hi = 0;
      repeat (16) begin
        @(negedge ref_clk);
        if (tick === 1'b1) hi++;
      end
      chk(hi, ticks[c]);
    end
    HOST.wr(16'h0013, 8'h00);
    run('{16'h7FFF, 16'h7FFF});
    chk(hi + pin_hi, 0);
    HOST.wr(16'h003A, 8'h01);
    for (int h = 0; h < 4; h++) begin
      HOST.wr(16'h003B, h[7:0]);
      run('{16'h7FFF});
      chk(hi, 1 + ext[h]);
      chk(pin_hi, hi);
    end
    HOST.wr(16'h003B, 8'h00);
    run('{16'h8000, 16'h8000, 16'h8000});
    chk(hi, 3);
    chk(first, 2);
    run('{16'h7FFE});
    chk(hi, 0);
    run('{16'h8001});
    chk(hi, 0);
    HOST.wr(16'h003C, 8'h01);
    foreach (th_s[i]) begin
      run('{th_s[i]});
      chk(hi, i % 2);
    end
    HOST.wr(16'h003C, 8'h00);
    HOST.wr(16'h003B, 8'h01);
    run('{16'h7FFF, 16'h0000, 16'h0000, 16'h7FFF});
    chk(hi, 7);
    chk(falls, 1);
    HOST.wr(16'h0013, 8'h01);
    run('{16'h7FFF, 16'h7FFF});
    chk(hi, 8);
    close_out();
  end
endmodule
